//--- src/omc_pkg.sv
package omc_pkg;

    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int NUM_IN = 2;

    // -------------------------------------------------------------------
    // Operating modes
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        OMC_SLEEP  = 2'b00,
        OMC_LIMP   = 2'b01,
        OMC_IDLE   = 2'b10,
        OMC_ACTIVE = 2'b11
    } omc_mode_type;

    // -------------------------------------------------------------------
    // Timing and reset values
    // -------------------------------------------------------------------
    localparam int    CLK_PERIOD_NS  = 10;
    localparam int    TRANS_TIME_NS  = 200;
    localparam int    TRANS_CYCLES   =
        (TRANS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int    TCNT_W         = 5;
    localparam logic [TCNT_W-1:0] TCNT_RESET = 5'h00;
    localparam logic [NUM_CH-1:0] CH_RESET   = 8'h00;
    localparam logic [NUM_CH-1:0] MAP_IN0_RESET = 8'h04;
    localparam logic [NUM_CH-1:0] MAP_IN1_RESET = 8'h08;
    localparam logic [NUM_CH-1:0] ERR_RESET  = 8'h00;

    // -------------------------------------------------------------------
    // Grouped supply qualifiers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic vs_present;
        logic vs_above_op;
        logic vdd_present;
        logic vdd_above_lop;
        logic vdd_above_uv;
    } omc_supply_type;

    // Software control bits as written over the link
    typedef struct packed {
        logic [NUM_CH-1:0] channel_on_bits;
        logic              stay_active_bit;
        logic              pwm_gen0_enable;
        logic              pwm_gen1_enable;
    } omc_ctrl_type;

endpackage : omc_pkg

//--- src/omc_mode_ctrl.sv
`timescale 1ns/10ps
module omc_mode_ctrl (
    input  wire logic                         clock_in,
    input  wire logic                         rst_in,
    input  wire logic                         enable_in,
    input  wire logic                         standby_pin_in,
    input  wire logic [omc_pkg::NUM_IN-1:0]   direct_input_pins_in,
    input  wire omc_pkg::omc_supply_type      supply_in,
    input  wire logic                         reg_write_in,
    input  wire omc_pkg::omc_ctrl_type        reg_wdata_in,
    input  wire logic                         soft_reset_bit_in,
    input  wire logic [omc_pkg::NUM_CH-1:0]   fault_event_in,
    output omc_pkg::omc_mode_type             mode_out,
    output logic                              power_on_out,
    output logic [omc_pkg::NUM_CH-1:0]        channel_drive_out,
    output logic                              link_enable_out,
    output logic                              link_write_enable_out,
    output logic                              regs_in_reset_out,
    output logic                              diag_enable_out,
    output logic                              in_transition_out,
    output logic [omc_pkg::NUM_CH-1:0]        channel_fault_latch_bits_out,
    output omc_pkg::omc_ctrl_type             ctrl_out
);

    // -------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------
    logic [omc_pkg::NUM_IN+6:0] sync_a;
    logic [omc_pkg::NUM_IN+6:0] sync_b;
    logic                       idle_pin;
    logic [omc_pkg::NUM_IN-1:0] in_pins;
    omc_pkg::omc_supply_type    sup;

    // Two flops on every pin and supply level
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (enable_in) begin
            sync_a <= {standby_pin_in, direct_input_pins_in, supply_in,
                       soft_reset_bit_in};
            sync_b <= sync_a;
        end
    end

    assign idle_pin = sync_b[omc_pkg::NUM_IN+6];
    assign in_pins  = sync_b[omc_pkg::NUM_IN+5:6];
    assign sup      = sync_b[5:1];

    // -------------------------------------------------------------------
    // Supply, pin and request qualifiers
    // -------------------------------------------------------------------
    logic any_supply;
    logic power_up;
    logic any_in;
    logic soft_rst;
    logic reg_reset;
    logic any_ch;
    logic turn_on_req;

    assign any_supply = sup.vs_present | sup.vdd_present;
    assign power_up   = any_supply & (any_in | idle_pin);
    assign any_in     = |in_pins;
    assign soft_rst   = sync_b[0];
    assign any_ch     = |ctrl_out.channel_on_bits;
    assign turn_on_req = any_in | any_ch | ctrl_out.pwm_gen0_enable
                         | ctrl_out.pwm_gen1_enable;

    // Internal power-on flag
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            power_on_out <= 1'b0;
        end else if (enable_in) begin
            power_on_out <= power_up
                & (sup.vs_above_op | sup.vdd_above_lop);
        end
    end

    // -------------------------------------------------------------------
    // Mode state machine
    // -------------------------------------------------------------------
    omc_pkg::omc_mode_type mode;
    omc_pkg::omc_mode_type next_mode;
    omc_pkg::omc_mode_type target;
    logic [omc_pkg::TCNT_W-1:0] tcnt;

    // Next mode decision
    always_comb begin
        next_mode = mode;
        unique case (mode)
            omc_pkg::OMC_SLEEP: begin
                if (power_up && idle_pin) begin
                    next_mode = omc_pkg::OMC_IDLE;
                end else if (power_up && any_in) begin
                    next_mode = omc_pkg::OMC_LIMP;
                end
            end
            omc_pkg::OMC_IDLE: begin
                if (!idle_pin && any_in) begin
                    next_mode = omc_pkg::OMC_LIMP;
                end else if (!idle_pin) begin
                    next_mode = omc_pkg::OMC_SLEEP;
                end else if (turn_on_req || ctrl_out.stay_active_bit) begin
                    next_mode = omc_pkg::OMC_ACTIVE;
                end
            end
            omc_pkg::OMC_ACTIVE: begin
                if (!idle_pin && any_in) begin
                    next_mode = omc_pkg::OMC_LIMP;
                end else if (!idle_pin) begin
                    next_mode = omc_pkg::OMC_SLEEP;
                end else if (!ctrl_out.stay_active_bit && !turn_on_req) begin
                    next_mode = omc_pkg::OMC_IDLE;
                end else if (!sup.vdd_above_uv && !any_in
                             && !ctrl_out.stay_active_bit) begin
                    next_mode = omc_pkg::OMC_IDLE;
                end
            end
            omc_pkg::OMC_LIMP: begin
                if (idle_pin) begin
                    next_mode = omc_pkg::OMC_IDLE;
                end else if (!any_in) begin
                    next_mode = omc_pkg::OMC_SLEEP;
                end
            end
        endcase
        if (!power_up) begin
            next_mode = omc_pkg::OMC_SLEEP;
        end
    end

    // Mode register, one mode at a time
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mode <= omc_pkg::OMC_SLEEP;
        end else if (enable_in) begin
            mode <= next_mode;
        end
    end

    // Transition latency counter before outputs may turn on
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            tcnt <= omc_pkg::TCNT_RESET;
        end else if (enable_in) begin
            if (next_mode != mode
                && (next_mode == omc_pkg::OMC_ACTIVE
                    || next_mode == omc_pkg::OMC_LIMP)) begin
                tcnt <= omc_pkg::TCNT_W'(omc_pkg::TRANS_CYCLES);
            end else if (tcnt != omc_pkg::TCNT_RESET) begin
                tcnt <= tcnt - 1'b1;
            end
        end
    end

    assign target            = mode;
    assign mode_out          = target;
    assign in_transition_out = (tcnt != omc_pkg::TCNT_RESET);

    // -------------------------------------------------------------------
    // Register bank
    // -------------------------------------------------------------------
    logic regs_usable;

    // Registers reset in sleep, standby low, logic undervoltage, limp home
    assign reg_reset = (mode == omc_pkg::OMC_SLEEP)
                     | !idle_pin | !sup.vdd_above_uv
                     | (mode == omc_pkg::OMC_LIMP);
    assign regs_usable = !reg_reset;
    assign regs_in_reset_out     = reg_reset;
    assign link_enable_out       = sup.vdd_above_uv
                                   & (mode == omc_pkg::OMC_IDLE
                                      | mode == omc_pkg::OMC_ACTIVE
                                      | mode == omc_pkg::OMC_LIMP);
    assign link_write_enable_out = regs_usable
                                   & (mode != omc_pkg::OMC_LIMP);
    assign diag_enable_out       = (mode == omc_pkg::OMC_ACTIVE)
                                   | (mode == omc_pkg::OMC_LIMP);

    // Control bits, written only when the link may write
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_out <= '0;
        end else if (enable_in) begin
            if (reg_reset || soft_rst) begin
                ctrl_out <= '0;
            end else if (reg_write_in && link_write_enable_out) begin
                ctrl_out <= reg_wdata_in;
            end
        end
    end

    // -------------------------------------------------------------------
    // Fault latches, per channel
    // -------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < omc_pkg::NUM_CH; g++) begin : g_err
            // Only sleep mode clears; idle and soft reset keep
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    channel_fault_latch_bits_out[g] <= 1'b0;
                end else if (enable_in) begin
                    if (fault_event_in[g] && diag_enable_out) begin
                        channel_fault_latch_bits_out[g] <= 1'b1;
                    end else if (mode == omc_pkg::OMC_SLEEP) begin
                        channel_fault_latch_bits_out[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // Channel drive
    // -------------------------------------------------------------------
    logic [omc_pkg::NUM_CH-1:0] pin_map;
    logic [omc_pkg::NUM_CH-1:0] next_drive;

    assign pin_map = (in_pins[0] ? omc_pkg::MAP_IN0_RESET : omc_pkg::CH_RESET)
                   | (in_pins[1] ? omc_pkg::MAP_IN1_RESET : omc_pkg::CH_RESET);

    // Outputs per mode, held off during transition latency
    always_comb begin
        next_drive = omc_pkg::CH_RESET;
        if (tcnt == omc_pkg::TCNT_RESET) begin
            if (mode == omc_pkg::OMC_ACTIVE) begin
                next_drive = pin_map | ctrl_out.channel_on_bits;
            end else if (mode == omc_pkg::OMC_LIMP) begin
                next_drive = pin_map;
            end
        end
    end

    // Registered drive; sleep and idle give zero
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            channel_drive_out <= omc_pkg::CH_RESET;
        end else if (enable_in) begin
            channel_drive_out <= next_drive;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    sequence s_enter_on;
        (next_mode == omc_pkg::OMC_ACTIVE) && (mode != omc_pkg::OMC_ACTIVE)
        && enable_in;
    endsequence

    chk_sleep_outputs_off: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (mode == omc_pkg::OMC_SLEEP) |=> (channel_drive_out == 8'h00)
                                         || !$past(enable_in))
        else $error("drive active after sleep");

    chk_idle_outputs_off: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (mode == omc_pkg::OMC_IDLE) && enable_in
        |=> channel_drive_out == 8'h00)
        else $error("drive active after idle");

    chk_turnon_delay: assert property (
        @(posedge clock_in) disable iff (rst_in)
        s_enter_on |=> in_transition_out && channel_drive_out == 8'h00)
        else $error("no turn-on latency");

    chk_limp_no_write: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (mode == omc_pkg::OMC_LIMP) |-> !link_write_enable_out)
        else $error("write allowed in limp home");

    chk_no_power_sleep: assert property (
        @(posedge clock_in) disable iff (rst_in)
        !power_up && enable_in |=> mode == omc_pkg::OMC_SLEEP)
        else $error("not sleep without power-up");

    chk_reset_clears: assert property (
        @(posedge clock_in) disable iff (rst_in)
        enable_in && (reg_reset || soft_rst) |=> ctrl_out == '0)
        else $error("control not cleared");

    chk_idle_keeps_err: assert property (
        @(posedge clock_in) disable iff (rst_in)
        (mode == omc_pkg::OMC_IDLE) && $past(mode == omc_pkg::OMC_IDLE)
        |-> ($past(channel_fault_latch_bits_out)
             & ~channel_fault_latch_bits_out) == 8'h00)
        else $error("fault bits lost in idle");

    chk_stay_active: assert property (
        @(posedge clock_in) disable iff (rst_in)
        mode == omc_pkg::OMC_ACTIVE && ctrl_out.stay_active_bit
        && idle_pin && power_up && enable_in
        |=> mode == omc_pkg::OMC_ACTIVE)
        else $error("left active with stay bit");

    chk_limp_entry: assert property (
        @(posedge clock_in) disable iff (rst_in)
        enable_in && power_up && !idle_pin && any_in
        && mode != omc_pkg::OMC_LIMP |=> mode == omc_pkg::OMC_LIMP)
        else $error("limp home not entered");

endmodule : omc_mode_ctrl

//--- test/omc_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Host controller model
// ---------------------------------------------------------------
module omc_host_model (
    input  wire logic                  clock_in,
    input  wire logic                  in_transition_in,
    output logic                       standby_pin_out,
    output logic [omc_pkg::NUM_IN-1:0] direct_input_pins_out,
    output omc_pkg::omc_supply_type    supply_out,
    output logic                       reg_write_out,
    output omc_pkg::omc_ctrl_type      reg_wdata_out,
    output logic                       soft_reset_bit_out
);
    // Quiet levels at time zero
    initial begin
        standby_pin_out       = 1'b0;
        direct_input_pins_out = 2'h0;
        supply_out            = 5'h00;
        reg_write_out         = 1'b0;
        reg_wdata_out         = 11'h000;
        soft_reset_bit_out    = 1'b0;
    end

    // Pin and supply levels, changed after a falling edge
    task automatic set_pins(input logic sb, input logic [1:0] p,
                            input logic [4:0] s);
        @(negedge clock_in);
        standby_pin_out       = sb;
        direct_input_pins_out = p;
        supply_out            = s;
    endtask : set_pins

    // One-cycle write, held back while the mode is changing
    task automatic write_ctrl(input logic [10:0] d);
        int n;
        n = 0;
        @(negedge clock_in);
        while (in_transition_in && n < 64) begin
            @(negedge clock_in);
            n++;
        end
        reg_write_out = 1'b1;
        reg_wdata_out = d;
        @(negedge clock_in);
        reg_write_out = 1'b0;
        reg_wdata_out = ~d; // Idle bus carries no stale word
    endtask : write_ctrl

    // Soft reset held past the input synchroniser
    task automatic soft_reset();
        @(negedge clock_in);
        soft_reset_bit_out = 1'b1;
        repeat (3) @(negedge clock_in);
        soft_reset_bit_out = 1'b0;
    endtask : soft_reset
endmodule : omc_host_model

//--- test/tb_operation_mode_controller.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
// ---------------------------------------------------------------
// Mode controller bench
// ---------------------------------------------------------------
module tb_operation_mode_controller;
    logic                    clock_in = 1'b0;
    logic                    rst_in   = 1'b1;
    logic                    sb, wr, srst, in_tr, pon, lnk, lwe, rrst, dg;
    logic [1:0]              pins, p;
    logic [7:0]              fev      = 8'h00;
    logic                    en       = 1'b1;
    logic [7:0]              drive, flt;
    logic [10:0]             c;
    logic [31:0]             rnd      = 32'h0000CA40;
    omc_pkg::omc_supply_type sup;
    omc_pkg::omc_ctrl_type   wd, ctrl;
    omc_pkg::omc_mode_type   mode;
    int                      err_total = 0;
    int                      total_checks = 0;

    // Clock generation
    always #(omc_pkg::CLK_PERIOD_NS / 2) clock_in = ~clock_in;

    omc_host_model host (.clock_in(clock_in), .in_transition_in(in_tr),
        .standby_pin_out(sb), .direct_input_pins_out(pins),
        .supply_out(sup), .reg_write_out(wr), .reg_wdata_out(wd),
        .soft_reset_bit_out(srst));

    omc_mode_ctrl DUT (.clock_in(clock_in), .rst_in(rst_in),
        .enable_in(en), .standby_pin_in(sb),
        .direct_input_pins_in(pins), .supply_in(sup),
        .reg_write_in(wr), .reg_wdata_in(wd), .soft_reset_bit_in(srst),
        .fault_event_in(fev), .mode_out(mode), .power_on_out(pon),
        .channel_drive_out(drive), .link_enable_out(lnk),
        .link_write_enable_out(lwe), .regs_in_reset_out(rrst),
        .diag_enable_out(dg), .in_transition_out(in_tr),
        .channel_fault_latch_bits_out(flt), .ctrl_out(ctrl));

    // Random source and expectations
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [1:0] exp_mode(input logic s,
        input logic [1:0] q, input logic [10:0] k);
        if (!s) return (q != 2'h0) ? omc_pkg::OMC_LIMP : omc_pkg::OMC_SLEEP;
        if (q != 2'h0 || k != 11'h000) return omc_pkg::OMC_ACTIVE;
        return omc_pkg::OMC_IDLE;
    endfunction : exp_mode

    function automatic logic [7:0] exp_drive(input logic [1:0] m,
        input logic [1:0] q, input logic [10:0] k);
        logic [7:0] mp;
        mp = (q[0] ? omc_pkg::MAP_IN0_RESET : 8'h00) |
             (q[1] ? omc_pkg::MAP_IN1_RESET : 8'h00);
        if (m == omc_pkg::OMC_LIMP) return mp;
        if (m == omc_pkg::OMC_ACTIVE) return mp | k[10:3];
        return 8'h00;
    endfunction : exp_drive

    // Waits long enough for sync, decision and transition
    task automatic settle();
        repeat (omc_pkg::TRANS_CYCLES + 8) @(negedge clock_in);
    endtask : settle

    task automatic check(input logic s, input logic [1:0] q,
                         input logic [10:0] k);
        logic [1:0] m;
        m = exp_mode(s, q, k);
        `CHK(mode, m)
        `CHK(drive, exp_drive(m, q, k))
    endtask : check

    // Write from idle and time the transition
    task automatic go_active(input logic [10:0] k);
        int n;
        n = 0;
        host.write_ctrl(k);
        while (!in_tr && n < 8) begin
            @(negedge clock_in);
            n++;
        end
        `CHK(drive, 8'h00)
        n = 0;
        while (in_tr && n < 64) begin
            @(negedge clock_in);
            n++;
        end
        `CHK(n, omc_pkg::TRANS_CYCLES)
        settle();
    endtask : go_active

    task automatic final_report();
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (16) @(negedge clock_in);
        rst_in = 1'b0;
        `CHK(mode, omc_pkg::OMC_SLEEP)
        `CHK(rrst, 1'b1)
        `CHK(drive, 8'h00)
        host.set_pins(1'b1, 2'h0, 5'h00);
        settle();
        `CHK(mode, omc_pkg::OMC_SLEEP)
        host.set_pins(1'b0, 2'h0, 5'h1F);
        settle();
        `CHK(mode, omc_pkg::OMC_SLEEP)
        host.set_pins(1'b1, 2'h0, 5'h10);
        settle();
        `CHK(pon, 1'b0)
        host.set_pins(1'b1, 2'h0, 5'h07);
        settle();
        `CHK(pon, 1'b1)
        host.set_pins(1'b1, 2'h0, 5'h1F);
        settle();
        check(1'b1, 2'h0, 11'h000);
        `CHK({lnk, rrst, dg}, 3'h4)
        // Clock enable low freezes the mode against a pin change
        en = 1'b0;
        host.set_pins(1'b0, 2'h0, 5'h1F);
        settle();
        `CHK(mode, omc_pkg::OMC_IDLE)
        host.set_pins(1'b1, 2'h0, 5'h1F);
        en = 1'b1;
        settle();
        `CHK(mode, omc_pkg::OMC_IDLE)
        // Random turn-on requests, corner words first
        for (int i = 0; i < 10; i++) begin
            rnd = xs(rnd);
            c = (i < 3) ? (11'h001 << i) : (rnd[10:0] | 11'h008);
            p = rnd[12:11];
            go_active(c);
            `CHK(ctrl, c)
            check(1'b1, 2'h0, c);
            host.set_pins(1'b1, p, 5'h1F);
            settle();
            check(1'b1, p, c);
            host.set_pins(1'b1, 2'h0, 5'h1F);
            settle();
            check(1'b1, 2'h0, c);
            host.write_ctrl(11'h000);
            settle();
            check(1'b1, 2'h0, 11'h000);
        end
        // Limp home for every nonzero input pattern
        for (int i = 1; i < 4; i++) begin
            host.set_pins(1'b0, i[1:0], 5'h1F);
            settle();
            check(1'b0, i[1:0], 11'h000);
            `CHK(lwe, 1'b0)
            host.write_ctrl(11'h7FF);
            settle();
            `CHK(ctrl, 11'h000)
        end
        host.set_pins(1'b0, 2'h0, 5'h1F);
        settle();
        check(1'b0, 2'h0, 11'h000);
        // Faults, soft reset and logic undervoltage
        host.set_pins(1'b1, 2'h0, 5'h1F);
        settle();
        go_active(11'h400);
        fev = 8'h5A;
        @(negedge clock_in);
        fev = 8'h00;
        host.soft_reset();
        settle();
        `CHK(ctrl, 11'h000)
        `CHK(flt, 8'h5A)
        `CHK(mode, omc_pkg::OMC_IDLE)
        fev = 8'hA5;
        @(negedge clock_in);
        fev = 8'h00;
        repeat (3) @(negedge clock_in);
        `CHK({dg, flt}, 9'h05A)
        go_active(11'h008);
        host.set_pins(1'b1, 2'h0, 5'h18);
        settle();
        `CHK(ctrl, 11'h000)
        `CHK(mode, omc_pkg::OMC_IDLE)
        `CHK({lnk, rrst}, 2'h1)
        `CHK(flt, 8'h5A)
        final_report();
    end
endmodule : tb_operation_mode_controller
